//--- design/ebs_pkg.sv
// Package for the expansion bus select and wait block
`default_nettype none
package ebs_pkg;
  // Cycle types per chip select
  typedef enum logic [2:0] {
    EBS_ASYNC_STROBE,
    EBS_SYNC_STROBE,
    EBS_DATA_STROBE,
    EBS_ZERO_TURNAROUND_SRAM,
    EBS_HOST_PORT
  } ebs_cycle_t;

  localparam int EBS_NUM_CS      = 8;
  localparam int EBS_NUM_MASTERS = 3;
  localparam int EBS_HOST_CS_LO  = 4;
  localparam logic [7:0]  EBS_CS_IDLE     = 8'hFF;
  localparam logic [3:0]  EBS_BE_IDLE     = 4'hF;
  localparam logic [2:0]  EBS_GNT_IDLE    = 3'h7;
  localparam logic [31:0] EBS_DATA_RESET  = 32'h0000_0000;
  localparam logic [2:0]  EBS_CFG_RESET   = 3'h0;

  // Outbound request from the transaction logic
  typedef struct packed {
    logic        valid;
    logic [2:0]  cs_idx;
    logic        write;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } ebs_out_req_t;

  // Inbound write toward the internal side
  typedef struct packed {
    logic        valid;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } ebs_in_wr_t;
endpackage
`default_nettype wire

//--- design/ebs_top.sv
// Expansion bus chip select, data, byte enable and wait handshake
`default_nettype none
module ebs_top
  import ebs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               exp_bus_clock,
  input  wire logic [23:0]        cs_cycle_cfg,
  input  wire ebs_out_req_t       out_req,
  output logic                    out_ack,
  output logic [31:0]             out_rdata,
  output ebs_in_wr_t              in_wr,
  input  wire logic               in_wr_req,
  input  wire logic               in_rd_req,
  output logic                    in_rd_take,
  input  wire logic [31:0]        in_rd_data,
  input  wire logic               exp_wait_n,
  input  wire logic [2:0]         ext_master_request_n,
  output logic [2:0]              ext_master_grant_n,
  output logic [7:0]              exp_chip_sel_n_o,
  output logic [7:0]              exp_chip_sel_n_oe_n,
  input  wire logic [7:0]         exp_chip_sel_n_i,
  output logic [31:0]             exp_data_bus_o,
  output logic                    exp_data_bus_oe_n,
  input  wire logic [31:0]        exp_data_bus_i,
  output logic [3:0]              exp_byte_lane_en_n_o,
  output logic                    exp_byte_lane_en_n_oe_n,
  input  wire logic [3:0]         exp_byte_lane_en_n_i
);

  // Bus owner: idle, our own access, or a granted master
  typedef enum logic [1:0] {
    EBS_IDLE,
    EBS_ACCESS,
    EBS_GRANTED
  } ebs_state_t;

  // Decode a per-select cycle type, demoting illegal host port use
  function automatic ebs_cycle_t cs_type(input logic [23:0] cfg,
                                         input logic [2:0]  idx);
    logic [2:0] raw;
    raw = cfg[idx*3 +: 3];
    // Codes past host port fall back to async strobe
    if (raw > 3'(EBS_HOST_PORT))
      cs_type = EBS_ASYNC_STROBE;
    else if (ebs_cycle_t'(raw) == EBS_HOST_PORT
             && 32'(idx) < EBS_HOST_CS_LO)
      cs_type = EBS_ASYNC_STROBE;
    else
      cs_type = ebs_cycle_t'(raw);
  endfunction

  // Active-low one-hot select for a chip select number
  function automatic logic [7:0] sel_low(input logic [2:0] idx);
    sel_low = ~(8'h01 << idx);
  endfunction

  // Two flops on every pin input, three on the link clock; first stage read only by second
  logic [2:0]  clk_s_r;
  logic        wait_s1_r;
  logic        wait_s2_r;
  logic [2:0]  req_s1_r;
  logic [2:0]  req_s2_r;
  logic [7:0]  cs_s1_r;
  logic [7:0]  cs_s2_r;
  logic [31:0] dat_s1_r;
  logic [31:0] dat_s2_r;
  logic [3:0]  be_s1_r;
  logic [3:0]  be_s2_r;

  // Link clock history; the edge is found past the second stage
  always_ff @(posedge clk)
  begin
    clk_s_r <= {clk_s_r[1:0], exp_bus_clock};
  end

  // Wait and request pins
  always_ff @(posedge clk)
  begin
    wait_s1_r <= exp_wait_n;
    wait_s2_r <= wait_s1_r;
    req_s1_r  <= ext_master_request_n;
    req_s2_r  <= req_s1_r;
  end

  // Chip select pins, watched only by the arbiter
  always_ff @(posedge clk)
  begin
    cs_s1_r <= exp_chip_sel_n_i;
    cs_s2_r <= cs_s1_r;
  end

  // Data and lanes; wide words are safe as pins hold a link period
  always_ff @(posedge clk)
  begin
    dat_s1_r <= exp_data_bus_i;
    dat_s2_r <= dat_s1_r;
    be_s1_r  <= exp_byte_lane_en_n_i;
    be_s2_r  <= be_s1_r;
  end

  // Rising edge of the link clock marks each bus cycle
  wire link_edge = clk_s_r[1] & ~clk_s_r[2];

  // Owner state, the request in flight and the granted master
  ebs_state_t   state_r;
  ebs_state_t   state_nxt;
  ebs_out_req_t cur_r;
  logic [1:0]   gnt_idx_r;

  // Wait only counts for async strobe and data strobe types
  wire ebs_cycle_t cur_type  = cs_type(cs_cycle_cfg, cur_r.cs_idx);
  wire wait_honoured = (cur_type == EBS_ASYNC_STROBE)
                     || (cur_type == EBS_DATA_STROBE);
  wire stalled       = wait_honoured && !wait_s2_r;

  // Lowest numbered requester wins; a fixed priority keeps it small
  wire [2:0] req_act  = ~req_s2_r;
  wire [1:0] req_pick = req_act[0] ? 2'h0 : req_act[1] ? 2'h1 : 2'h2;

  // Bus looks free only when nobody holds a chip select low
  wire bus_quiet     = &cs_s2_r;
  // Outbound requests beat masters; a steady stream starves them
  wire grant_start   = link_edge && |req_act && bus_quiet
                       && !out_req.valid;
  wire grant_end     = link_edge && !req_act[gnt_idx_r];

  // Link edge closes an access unless an honoured wait holds it
  wire access_done   = link_edge && !stalled;

  // Bus owner sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      EBS_IDLE:
        if (grant_start)
          state_nxt = EBS_GRANTED;
        else if (link_edge && out_req.valid)
          state_nxt = EBS_ACCESS;
      EBS_ACCESS:
        if (access_done)
          state_nxt = EBS_IDLE;
      EBS_GRANTED:
        if (grant_end)
          state_nxt = EBS_IDLE;
      default:
        state_nxt = EBS_IDLE;
    endcase
  end

  wire start_access = state_r == EBS_IDLE && state_nxt == EBS_ACCESS;
  wire finish_acc   = state_r == EBS_ACCESS && access_done;
  wire granted_nxt  = state_nxt == EBS_GRANTED;
  wire access_nxt   = state_nxt == EBS_ACCESS;
  wire read_done    = finish_acc && !cur_r.write;

  // Fields for the coming link cycle: fresh request at launch, else held
  wire [2:0] cs_idx_nxt = start_access ? out_req.cs_idx : cur_r.cs_idx;
  wire       write_nxt  = start_access ? out_req.write : cur_r.write;
  wire [3:0] be_nxt     = start_access ? out_req.be_n : cur_r.be_n;
  wire [1:0] owner_nxt  = grant_start ? req_pick : gnt_idx_r;

  // Pin levels chosen once per link edge
  wire [7:0] cs_pin_nxt  = access_nxt ? sel_low(cs_idx_nxt)
                                      : EBS_CS_IDLE;
  wire [7:0] cs_oe_nxt   = granted_nxt ? 8'hFF : 8'h00;
  wire [3:0] be_pin_nxt  = access_nxt ? be_nxt : EBS_BE_IDLE;
  wire       d_oe_nxt    = !(access_nxt && write_nxt);
  wire [2:0] gnt_pin_nxt = granted_nxt ? ~(3'h1 << owner_nxt)
                                       : EBS_GNT_IDLE;

  // Inbound strobes, one per link edge while a master owns the bus
  wire in_wr_fire = state_r == EBS_GRANTED && in_wr_req && link_edge;
  wire in_rd_fire = state_r == EBS_GRANTED && in_rd_req && link_edge;

  // Capture the request at launch so wait holds it exactly in place
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r   <= EBS_IDLE;
      cur_r     <= '0;
      gnt_idx_r <= 2'd0;
    end
    else
    begin
      state_r <= state_nxt;
      if (start_access)
        cur_r <= out_req;
      if (grant_start)
        gnt_idx_r <= req_pick;
    end
  end

  // Select pins and their enable; released to a granted master
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exp_chip_sel_n_o    <= EBS_CS_IDLE;
      exp_chip_sel_n_oe_n <= 8'h00;
    end
    else if (link_edge)
    begin
      exp_chip_sel_n_o    <= cs_pin_nxt;
      exp_chip_sel_n_oe_n <= cs_oe_nxt;
    end
  end

  // Data pins; the word changes only at launch, so a wait holds it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exp_data_bus_o    <= EBS_DATA_RESET;
      exp_data_bus_oe_n <= 1'b1;
    end
    else if (link_edge)
    begin
      if (start_access)
        exp_data_bus_o <= out_req.wdata;
      exp_data_bus_oe_n <= d_oe_nxt;
    end
  end

  // Lane pins, driven except while a master owns the bus
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exp_byte_lane_en_n_o    <= EBS_BE_IDLE;
      exp_byte_lane_en_n_oe_n <= 1'b0;
    end
    else if (link_edge)
    begin
      exp_byte_lane_en_n_o    <= be_pin_nxt;
      exp_byte_lane_en_n_oe_n <= granted_nxt;
    end
  end

  // Grant pins, launched on the link edge like every other pin
  always_ff @(posedge clk)
  begin
    if (rst)
      ext_master_grant_n <= EBS_GNT_IDLE;
    else if (link_edge)
      ext_master_grant_n <= gnt_pin_nxt;
  end

  // Outbound answer: ack pulse, read word caught at the closing edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_ack   <= 1'b0;
      out_rdata <= EBS_DATA_RESET;
    end
    else
    begin
      out_ack <= finish_acc;
      if (read_done)
        out_rdata <= dat_s2_r;
    end
  end

  // Inbound side: lanes and word follow the pins, strobes pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_wr      <= '0;
      in_rd_take <= 1'b0;
    end
    else
    begin
      in_wr.valid <= in_wr_fire;
      in_wr.be_n  <= be_s2_r;
      in_wr.wdata <= dat_s2_r;
      // Whole words only; lanes play no part in a read
      in_rd_take  <= in_rd_fire;
    end
  end

  // Inbound read data is not returned on pins by this block
  wire unused_ok = ^in_rd_data;

endmodule
`default_nettype wire

//--- bench/ebs_monitor.sv
// Assertion checker for the expansion bus select and wait block
`default_nettype none
module ebs_monitor
  import ebs_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic [23:0]  cs_cycle_cfg,
  input wire ebs_out_req_t out_req,
  input wire logic         out_ack,
  input wire logic         exp_wait_n,
  input wire logic [2:0]   ext_master_grant_n,
  input wire logic [7:0]   exp_chip_sel_n_o,
  input wire logic [7:0]   exp_chip_sel_n_oe_n,
  input wire logic         exp_data_bus_oe_n,
  input wire logic         exp_byte_lane_en_n_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Unmapped codes and host port below select 4 behave as async
  wire logic [2:0] cur_type = cs_cycle_cfg[3*out_req.cs_idx +: 3];
  wire logic       honour   = cur_type == 3'h0 || cur_type == 3'h2
    || cur_type > 3'h4 || (cur_type == 3'h4 && !out_req.cs_idx[2]);
  // Wait low long enough to clear the synchroniser
  sequence s_wait_held;
    !exp_wait_n [*5];
  endsequence
  a_wait_halts: assert property ((out_req.valid && honour) throughout
    s_wait_held |-> !out_ack) else $error("ack during wait");
  a_ack_single: assert property (out_ack |=> !out_ack)
    else $error("ack longer than one cycle");
  a_ack_idle_cs: assert property (out_ack |-> exp_chip_sel_n_o == EBS_CS_IDLE)
    else $error("select left low after ack");
  a_one_select: assert property ($onehot0(~exp_chip_sel_n_o))
    else $error("two selects low");
  a_cs_target: assert property (out_req.valid && exp_chip_sel_n_o !=
    EBS_CS_IDLE |-> exp_chip_sel_n_o == ~(8'h01 << out_req.cs_idx))
    else $error("wrong select low");
  a_data_write_only: assert property (!exp_data_bus_oe_n |-> out_req.valid
    && out_req.write) else $error("data driven outside write");
  a_be_release: assert property (ext_master_grant_n != EBS_GNT_IDLE &&
    $past(ext_master_grant_n) != EBS_GNT_IDLE |-> exp_byte_lane_en_n_oe_n
    && exp_chip_sel_n_oe_n == EBS_CS_IDLE) else $error("pins kept");
  a_grant_single: assert property ($onehot0(~ext_master_grant_n))
    else $error("two grants");
endmodule
`default_nettype wire

//--- bench/ebs_periph.sv
// Peripheral model: read word and wait insertion
`default_nettype none
module ebs_periph
(
  input  wire logic        clk,
  input  wire logic [7:0]  sel_n,
  input  wire logic        slow,
  input  wire logic [31:0] word,
  output logic             wait_n,
  output logic [31:0]      rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  hold_r;
  logic [31:0] last_r;
  // Slow device holds wait for 48 clocks; released data shows the inverse
  always_ff @(posedge clk)
  begin
    hold_r <= &sel_n ? 6'h00 : hold_r + 6'(hold_r != 6'h30);
    last_r <= &sel_n ? ~word : word;
  end
  assign wait_n = &sel_n || !slow || hold_r == 6'h30;
  assign rdata  = last_r;
endmodule
`default_nettype wire

//--- bench/ebs_top_bench.sv
// Testbench for the expansion bus select and wait block
`default_nettype none
module ebs_top_bench
  import ebs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rst, lclk, ack, take, wait_n, d_oe, be_oe, slow;
  logic         wr_req, rd_req;
  logic [2:0]   mreq_n, gnt_n;
  logic [3:0]   be_o, be_i, mbe;
  logic [7:0]   cs_o, cs_oe, cs_i, last_cs;
  logic [23:0]  cfg;
  logic [31:0]  rdata, d_o, d_i, pd, word, mdata;
  logic [40:0]  cur;
  logic [40:0]  exp_q[$];
  ebs_out_req_t req;
  ebs_in_wr_t   inw;
  int           num_errors, compares, dur;
  // Wire levels: pull-ups on selects, master drives lanes when granted
  assign cs_i = cs_o | cs_oe;
  assign be_i = be_oe ? mbe : be_o;
  assign d_i  = !d_oe ? d_o : (gnt_n != EBS_GNT_IDLE ? mdata : pd);
  always #5 clk = ~clk;
  always #80 lclk = ~lclk;
  ebs_top ebs_top_i (.clk, .rst, .exp_bus_clock(lclk), .cs_cycle_cfg(cfg),
    .out_req(req), .out_ack(ack), .out_rdata(rdata), .in_wr(inw),
    .in_wr_req(wr_req), .in_rd_req(rd_req), .in_rd_take(take),
    .in_rd_data(32'h0000_0000), .exp_wait_n(wait_n),
    .ext_master_request_n(mreq_n), .ext_master_grant_n(gnt_n),
    .exp_chip_sel_n_o(cs_o), .exp_chip_sel_n_oe_n(cs_oe),
    .exp_chip_sel_n_i(cs_i), .exp_data_bus_o(d_o), .exp_data_bus_oe_n(d_oe),
    .exp_data_bus_i(d_i), .exp_byte_lane_en_n_o(be_o),
    .exp_byte_lane_en_n_oe_n(be_oe), .exp_byte_lane_en_n_i(be_i));
  ebs_periph ebs_periph_i (.clk, .sel_n(cs_i), .slow, .word, .wait_n,
    .rdata(pd));
  task automatic check(input string what, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One outbound access of a given cycle type; stretch expected if honoured and slow
  task automatic access(input logic [2:0] cs, ty);
    logic hon, sl, wr;
    logic [3:0] be;
    logic [31:0] dat;
    int n;
    sl = 1'($urandom);
    wr = 1'($urandom);
    be = 4'($urandom);
    dat = $urandom;
    hon = ty == 3'h0 || ty == 3'h2 || ty > 3'h4 || (ty == 3'h4 && cs < 3'h4);
    exp_q.push_back({hon && sl, wr, cs, be, dat});
    cfg[3*cs +: 3] <= ty;
    slow <= sl;
    req <= {1'b1, cs, wr, be, dat};
    for (n = 0; n < 300 && ack !== 1'b1; n++) @(posedge clk);
    check("ack", ack, 1'b1);
    req.valid <= 1'b0;
    @(posedge clk);
  endtask
  // External master: grant, lane release, inbound write and read
  task automatic master(input int m);
    int n;
    mreq_n[m] <= 1'b0;
    {wr_req, rd_req} <= 2'h3;
    mbe <= 4'($urandom);
    mdata <= $urandom;
    for (n = 0; n < 200 && gnt_n[m] !== 1'b0; n++) @(posedge clk);
    check("grant", gnt_n, 3'(~(3'h1 << m)));
    check("lane_oe", be_oe, 1'b1);
    for (n = 0; n < 200 && inw.valid !== 1'b1; n++) @(posedge clk);
    check("in_valid", inw.valid, 1'b1);
    check("in_lanes", {inw.be_n, inw.wdata}, {mbe, mdata});
    for (n = 0; n < 200 && take !== 1'b1; n++) @(posedge clk);
    check("rd_take", take, 1'b1);
    mreq_n <= EBS_GNT_IDLE;
    {wr_req, rd_req} <= 2'h0;
    for (n = 0; n < 200 && gnt_n !== EBS_GNT_IDLE; n++) @(posedge clk);
    check("grant_off", gnt_n, EBS_GNT_IDLE);
  endtask
  // Result watcher: one note per access, taken when its select falls
  always @(posedge clk)
  begin
    if (cs_o != EBS_CS_IDLE && last_cs == EBS_CS_IDLE && exp_q.size() > 0)
    begin
      cur = exp_q.pop_front();
      dur = 0;
      check("select", cs_o, 8'(~(8'h01 << cur[38:36])));
      check("lanes", be_o, cur[35:32]);
      if (cur[39]) check("wdata", d_o, cur[31:0]);
    end
    dur++;
    if (ack === 1'b1) check("stretch", dur >= 40, cur[40]);
    if (ack === 1'b1 && !cur[39]) check("rdata", rdata, word);
    last_cs = cs_o;
  end
  initial
  begin
    {clk, lclk, rst, slow, wr_req, rd_req} = 6'h08;
    {cfg, req, mreq_n, mbe, mdata, last_cs} = '0;
    mreq_n = EBS_GNT_IDLE;
    word = 32'h5A3C_96E1;
    void'($urandom(32'he45d_c00b));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 24; i++) access(3'(i * 5), 3'(i / 3));
    for (int m = 0; m < 3; m++) master(m);
    wrap_up();
  end
  initial
  begin
    #200us;
    num_errors++;
    wrap_up();
  end
endmodule
bind ebs_top ebs_monitor ebs_monitor_i (.clk, .rst, .cs_cycle_cfg,
  .out_req, .out_ack, .exp_wait_n, .ext_master_grant_n, .exp_chip_sel_n_o,
  .exp_chip_sel_n_oe_n, .exp_data_bus_oe_n, .exp_byte_lane_en_n_oe_n);
`default_nettype wire
